// ===== design/ubr_uart.sv
// ubr_uart.sv: serial receiver with two-word buffer, error flags, break send
// assumes: classic wishbone master on i_clk, serial line asynchronous
`timescale 1ns/100ps
`include "ubr_cfg.svh"
module ubr_uart (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_ce,
    input wire ubr_pkg::ubr_wb_req_s i_wb,
    output logic [31:0] o_wb_dat,
    output logic o_wb_ack,
    input wire logic i_rx,
    output logic o_tx,
    output logic o_tx_oe,
    output logic o_rx_irq
);
    import ubr_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // registers and bus
    logic [8:0] ctrl_reg;
    logic [15:0] div_reg;
    logic ack_reg;
    logic [31:0] rdat_reg;
    logic stat_seen_reg;
    logic [8:0] status_vec;
    logic acc, wr, rd_stat, rd_data;
    logic pop;
    logic [1:0] cnt_reg;
    ubr_word_s fifo_mem [0:1];
    logic rd_ptr_reg;
    ubr_word_s head_word;
    assign head_word = fifo_mem[rd_ptr_reg];
    assign acc = i_wb.cyc && i_wb.stb && !ack_reg;
    assign wr = acc && i_wb.we;
    assign rd_stat = acc && !i_wb.we && i_wb.adr == `UBR_OFS_STAT;
    assign rd_data = acc && !i_wb.we && i_wb.adr == `UBR_OFS_DATA;

    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            ctrl_reg <= `UBR_CTRL_RST;
            div_reg <= `UBR_DIV_RST;
        end
        else if (i_ce && wr)
        begin
            if (i_wb.adr == `UBR_OFS_CTRL && i_wb.sel[0])
                ctrl_reg[7:0] <= i_wb.dat[7:0];
            if (i_wb.adr == `UBR_OFS_DIV && i_wb.sel[0])
                div_reg[7:0] <= i_wb.dat[7:0];
            if (i_wb.adr == `UBR_OFS_DIV && i_wb.sel[1])
                div_reg[15:8] <= i_wb.dat[15:8];
        end
        else if (i_ce && pop)
            ctrl_reg[`UBR_C_RX9] <= head_word.data[8];
    end

    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            ack_reg <= 1'b0;
            rdat_reg <= 32'h0000_0000;
            stat_seen_reg <= 1'b0;
        end
        else if (i_ce)
        begin
            ack_reg <= acc;
            if (acc && !i_wb.we)
            begin
                case (i_wb.adr)
                    `UBR_OFS_CTRL: rdat_reg <= {23'h0, ctrl_reg};
                    `UBR_OFS_STAT: rdat_reg <= {23'h0, status_vec};
                    `UBR_OFS_DATA: rdat_reg <= {23'h0, head_word.data};
                    `UBR_OFS_DIV: rdat_reg <= {16'h0, div_reg};
                    default: rdat_reg <= 32'h0000_0000;
                endcase
            end
            if (rd_stat)
                stat_seen_reg <= 1'b1;
            else if (rd_data || wr)
                stat_seen_reg <= 1'b0;
        end
    end
    assign o_wb_ack = ack_reg;
    assign o_wb_dat = rdat_reg;
    // status then data read releases the head word
    assign pop = rd_data && stat_seen_reg && cnt_reg != 2'h0;

    ////////////////////////////////////////////////////////////////////////
    // x16 tick and line synchroniser
    logic [15:0] os_cnt_reg;
    logic tick;
    assign tick = i_ce && os_cnt_reg == div_reg;
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            os_cnt_reg <= 16'h0000;
        else if (i_ce)
            os_cnt_reg <= tick ? 16'h0000 : os_cnt_reg + 16'h0001;
    end

    logic [2:0] sync_reg;
    logic line_reg;
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            sync_reg <= 3'h7;
            line_reg <= 1'b1;
        end
        else if (i_ce)
        begin
            sync_reg <= {sync_reg[1:0], i_rx};
            if (sync_reg[2] == sync_reg[1])
                line_reg <= sync_reg[2];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // receiver
    ubr_rx_e rx_state_reg;
    logic [3:0] os_reg;
    logic [3:0] bit_reg;
    logic [8:0] rsr_reg;
    logic [2:0] smp_reg;
    logic noise_reg, par_reg;
    logic vote, bit_end;
    logic push;
    ubr_word_s push_word;
    logic rx_en, nine;
    assign rx_en = ctrl_reg[`UBR_C_RX_ENABLE_BIT];
    assign nine = ctrl_reg[`UBR_C_NINE];
    assign vote = (smp_reg[0] & smp_reg[1]) | (smp_reg[0] & smp_reg[2])
        | (smp_reg[1] & smp_reg[2]);
    assign bit_end = tick && os_reg == `UBR_OS_LAST;

    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            rx_state_reg <= RX_OFF;
            os_reg <= 4'h0;
            bit_reg <= 4'h0;
            rsr_reg <= 9'h000;
            smp_reg <= 3'h7;
            noise_reg <= 1'b0;
            par_reg <= 1'b0;
            push <= 1'b0;
            push_word <= '0;
        end
        else if (i_ce)
        begin
            push <= 1'b0;
            if (tick)
            begin
                os_reg <= os_reg + 4'h1;
                // three samples around the bit centre
                if (os_reg >= `UBR_OS_MID - 4'h1
                    && os_reg <= `UBR_OS_MID + 4'h1)
                    smp_reg <= {smp_reg[1:0], line_reg};
            end
            case (rx_state_reg)
                RX_OFF:
                    if (rx_en)
                        rx_state_reg <= RX_WAITHI;
                RX_HUNT:
                    if (tick && !line_reg)
                    begin
                        rx_state_reg <= RX_START;
                        os_reg <= 4'h1;
                        noise_reg <= 1'b0;
                    end
                RX_START:
                    if (bit_end)
                    begin
                        if (vote)
                            rx_state_reg <= RX_HUNT;
                        else
                        begin
                            rx_state_reg <= RX_DATA;
                            bit_reg <= 4'h0;
                            par_reg <= 1'b0;
                        end
                    end
                RX_DATA:
                    if (bit_end)
                    begin
                        rsr_reg <= nine ? {vote, rsr_reg[8:1]}
                            : {1'b0, vote, rsr_reg[7:1]};
                        par_reg <= par_reg ^ vote;
                        bit_reg <= bit_reg + 4'h1;
                        if (bit_reg == (nine ? 4'h8 : 4'h7))
                            rx_state_reg <= RX_STOP;
                    end
                RX_STOP:
                    if (bit_end)
                    begin
                        // break: zero data, framing error, wait for high line
                        push <= 1'b1;
                        push_word.frame_err_flag <= !vote;
                        push_word.data <= rsr_reg;
                        push_word.noise <= noise_reg;
                        push_word.parity_err_flag <= ctrl_reg[`UBR_C_PAR_ON]
                            && (par_reg ^ ctrl_reg[`UBR_C_PAR_ODD]);
                        rx_state_reg <= vote ? RX_HUNT : RX_WAITHI;
                    end
                RX_WAITHI:
                    if (line_reg)
                        rx_state_reg <= RX_HUNT;
                default:
                    rx_state_reg <= RX_OFF;
            endcase
            if (tick && os_reg == `UBR_OS_MID + 4'h1
                && smp_reg[1:0] != {2{line_reg}})
                noise_reg <= 1'b1;
            if (!rx_en)
                rx_state_reg <= RX_OFF;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // two-word buffer and flags
    logic ovr_reg, frame_err_flag_reg, noise_f_reg, parity_err_flag_reg, irq_reg;
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            cnt_reg <= 2'h0;
            rd_ptr_reg <= 1'b0;
            fifo_mem[0] <= '0;
            fifo_mem[1] <= '0;
            ovr_reg <= 1'b0;
            frame_err_flag_reg <= 1'b0;
            noise_f_reg <= 1'b0;
            parity_err_flag_reg <= 1'b0;
            irq_reg <= 1'b0;
        end
        else if (i_ce)
        begin
            irq_reg <= 1'b0;
            if (pop)
            begin
                ovr_reg <= 1'b0;
                frame_err_flag_reg <= 1'b0;
                noise_f_reg <= 1'b0;
                parity_err_flag_reg <= 1'b0;
                rd_ptr_reg <= !rd_ptr_reg;
            end
            if (push && (cnt_reg != 2'h2 || pop))
            begin
                fifo_mem[rd_ptr_reg ^ cnt_reg[0]] <= push_word;
                frame_err_flag_reg <= push_word.frame_err_flag;
                noise_f_reg <= push_word.noise;
                parity_err_flag_reg <= push_word.parity_err_flag;
                irq_reg <= ctrl_reg[`UBR_C_RIE];
            end
            else if (push)
            begin
                ovr_reg <= 1'b1;
                irq_reg <= ctrl_reg[`UBR_C_RIE];
            end
            if (push && !pop && cnt_reg != 2'h2)
                cnt_reg <= cnt_reg + 2'h1;
            else if (pop && !push)
                cnt_reg <= cnt_reg - 2'h1;
            if (!rx_en)
            begin
                cnt_reg <= 2'h0;
                ovr_reg <= 1'b0;
            end
        end
    end
    assign o_rx_irq = irq_reg;

    ////////////////////////////////////////////////////////////////////////
    // break transmitter
    ubr_tx_e tx_state_reg;
    logic [15:0] hold_reg;
    logic brk_armed_reg;
    logic [3:0] tos_reg;
    logic [3:0] zcnt_reg;
    logic stop2_reg;
    logic tx_reg;
    logic brk;
    assign brk = ctrl_reg[`UBR_C_BRK];
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            hold_reg <= 16'h0000;
            brk_armed_reg <= 1'b0;
        end
        else if (i_ce)
        begin
            if (!brk)
            begin
                hold_reg <= 16'h0000;
                brk_armed_reg <= 1'b0;
            end
            else if (hold_reg > div_reg)
                brk_armed_reg <= 1'b1;
            else
                hold_reg <= hold_reg + 16'h0001;
        end
    end

    logic tbit;
    assign tbit = tick && tos_reg == `UBR_OS_LAST;
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            tx_state_reg <= TX_IDLE;
            tos_reg <= 4'h0;
            zcnt_reg <= 4'h0;
            stop2_reg <= 1'b0;
            tx_reg <= 1'b1;
        end
        else if (i_ce)
        begin
            if (tick)
                tos_reg <= tos_reg + 4'h1;
            case (tx_state_reg)
                TX_IDLE:
                begin
                    tx_reg <= 1'b1;
                    if (brk_armed_reg && tbit)
                    begin
                        tx_state_reg <= TX_START;
                        tx_reg <= 1'b0;
                    end
                end
                TX_START:
                    if (tbit)
                    begin
                        tx_state_reg <= TX_ZERO;
                        zcnt_reg <= 4'h0;
                    end
                TX_ZERO:
                    if (tbit)
                    begin
                        zcnt_reg <= zcnt_reg + 4'h1;
                        if (zcnt_reg == `UBR_BRK_BITS - 4'h1)
                        begin
                            zcnt_reg <= 4'h0;
                            if (!brk)
                            begin
                                tx_state_reg <= TX_STOP;
                                tx_reg <= 1'b1;
                                stop2_reg <= ctrl_reg[`UBR_C_STOP2];
                            end
                        end
                    end
                TX_STOP:
                    if (tbit)
                    begin
                        if (stop2_reg)
                            stop2_reg <= 1'b0;
                        else
                            tx_state_reg <= TX_IDLE;
                    end
                default:
                    tx_state_reg <= TX_IDLE;
            endcase
        end
    end
    // break frames drive no transmit-empty or transmit interrupt
    assign o_tx = tx_reg;
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            o_tx_oe <= 1'b0;
        else if (i_ce)
            o_tx_oe <= ctrl_reg[`UBR_C_TXEN];
    end

    // receiver idle flag and status word
    assign status_vec = {2'b00, tx_state_reg == TX_IDLE,
        rx_state_reg == RX_HUNT || rx_state_reg == RX_OFF
            || rx_state_reg == RX_WAITHI,
        parity_err_flag_reg, noise_f_reg, frame_err_flag_reg, ovr_reg,
        cnt_reg != 2'h0};

    ////////////////////////////////////////////////////////////////////////
    // checks
    property p_ovr_irq;
        @(posedge i_clk) disable iff (!i_arst_n)
        (i_ce && push && cnt_reg == 2'h2 && !pop && ctrl_reg[`UBR_C_RIE])
            |=> (o_rx_irq && ovr_reg);
    endproperty
    a_ovr_irq: assert property (p_ovr_irq) else $error("overrun no irq");
    property p_avail;
        @(posedge i_clk) disable iff (!i_arst_n)
        (i_ce && push && cnt_reg == 2'h0) |=> status_vec[`UBR_S_AVAIL];
    endproperty
    a_avail: assert property (p_avail) else $error("avail not set");
    property p_brk_gate;
        @(posedge i_clk) disable iff (!i_arst_n)
        (tx_state_reg == TX_IDLE && !brk_armed_reg) |=> tx_reg;
    endproperty
    a_brk_gate: assert property (p_brk_gate) else $error("early break");
    property p_clear;
        @(posedge i_clk) disable iff (!i_arst_n)
        (i_ce && $fell(status_vec[`UBR_S_AVAIL])) |-> $past(pop) || !rx_en;
    endproperty
    a_clear: assert property (p_clear) else $error("bad clear");
    property p_brk_wait;
        @(posedge i_clk) disable iff (!i_arst_n)
        (i_ce && rx_en && rx_state_reg == RX_STOP && bit_end && !vote)
            |=> rx_state_reg == RX_WAITHI;
    endproperty
    a_brk_wait: assert property (p_brk_wait) else $error("no wait");
    property p_noise;
        @(posedge i_clk) disable iff (!i_arst_n)
        (i_ce && push && cnt_reg != 2'h2)
            |=> noise_f_reg == $past(push_word.noise);
    endproperty
    a_noise: assert property (p_noise) else $error("noise flag");
endmodule : ubr_uart

// ===== design/ubr_cfg.svh
// ubr_cfg.svh: offsets, field positions, reset values and timing counts
// assumes: included by the package and the uart design file
`ifndef UBR_CFG_SVH
`define UBR_CFG_SVH
`define UBR_ADDR_W 4
`define UBR_OFS_CTRL 4'h0
`define UBR_OFS_STAT 4'h4
`define UBR_OFS_DATA 4'h8
`define UBR_OFS_DIV 4'hC
// control register fields
`define UBR_C_RX_ENABLE_BIT 0
`define UBR_C_NINE 1
`define UBR_C_PAR_ON 2
`define UBR_C_PAR_ODD 3
`define UBR_C_STOP2 4
`define UBR_C_BRK 5
`define UBR_C_RIE 6
`define UBR_C_TXEN 7
`define UBR_C_RX9 8
// status register fields
`define UBR_S_AVAIL 0
`define UBR_S_OVR 1
`define UBR_S_FRAME_ERR_FLAG 2
`define UBR_S_NOISE 3
`define UBR_S_PARITY_ERR_FLAG 4
`define UBR_S_IDLE 5
`define UBR_S_TIDLE 6
`define UBR_CTRL_RST 9'h000
`define UBR_DIV_RST 16'h0000
`define UBR_BRK_BITS 4'hD
`define UBR_OS_LAST 4'hF
`define UBR_OS_MID 4'h7
`endif

// ===== design/ubr_pkg.sv
// ubr_pkg.sv: types for the break-capable receiver uart
// assumes: ubr_cfg.svh on the include path
`include "ubr_cfg.svh"
package ubr_pkg;
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [3:0] sel;
        logic [`UBR_ADDR_W-1:0] adr;
        logic [31:0] dat;
    } ubr_wb_req_s;
    typedef struct packed {
        logic frame_err_flag;
        logic noise;
        logic parity_err_flag;
        logic [8:0] data;
    } ubr_word_s;
    typedef enum logic [2:0] {
        RX_OFF, RX_HUNT, RX_START, RX_DATA, RX_PAR, RX_STOP, RX_WAITHI
    } ubr_rx_e;
    typedef enum logic [1:0] {TX_IDLE, TX_START, TX_ZERO, TX_STOP} ubr_tx_e;
endpackage : ubr_pkg

// ===== bench/ubr_remote.sv
// ubr_remote.sv: remote serial device on the far side of the uart line
// assumes: bench clock on i_clk, bit time of BIT clocks on both directions
`timescale 1ns/100ps
module ubr_remote #(
    parameter int BIT = 32
) (
    input wire logic i_clk,
    input wire logic i_line_in,
    output logic o_line_out
);
    int low_run = 0;
    int last_low = 0;
    initial o_line_out = 1'b1;
    ////////////////////////////////////////////////////////////////////////
    // frame sender: start, data lsb first, one stop, one idle bit high
    task automatic send(input logic [9:0] data, input int nbits,
        input logic stop);
        int i;
        @(posedge i_clk);
        o_line_out <= 1'b0;
        repeat (BIT) @(posedge i_clk);
        for (i = 0; i < nbits; i++)
        begin
            o_line_out <= data[i];
            repeat (BIT) @(posedge i_clk);
        end
        o_line_out <= stop;
        repeat (BIT) @(posedge i_clk);
        o_line_out <= 1'b1;
        repeat (BIT) @(posedge i_clk);
    endtask : send
    // long low line, then a high stop level before anything else
    task automatic hold_low(input int bits);
        @(posedge i_clk);
        o_line_out <= 1'b0;
        repeat (bits * BIT) @(posedge i_clk);
        o_line_out <= 1'b1;
        repeat (2 * BIT) @(posedge i_clk);
    endtask : hold_low
    ////////////////////////////////////////////////////////////////////////
    // measures each low run seen on the device's transmit line
    always @(posedge i_clk)
    begin
        if (i_line_in === 1'b0)
            low_run <= low_run + 1;
        else
        begin
            if (low_run != 0)
                last_low <= low_run;
            low_run <= 0;
        end
    end
endmodule : ubr_remote

// ===== bench/tb.sv
// tb.sv: register level tests of the break-capable receiver uart
// assumes: ubr_cfg.svh on the include path, remote model in ubr_remote.sv
`timescale 1ns/100ps
`include "ubr_cfg.svh"
module tb;
    import ubr_pkg::*;
    localparam int DIV = 1;
    localparam int BIT = (DIV + 1) * 16;
    localparam logic [31:0] C_RX = 32'h0000_0041;
    localparam logic [31:0] C_NINE = 32'h0000_0001 << `UBR_C_NINE;
    localparam logic [31:0] C_PAR = 32'h0000_0001 << `UBR_C_PAR_ON;
    localparam logic [31:0] C_BRK = 32'h0000_0001 << `UBR_C_BRK;
    localparam logic [31:0] C_TX = 32'h0000_0001 << `UBR_C_TXEN;
    localparam logic [31:0] C_R9 = 32'h0000_0001 << `UBR_C_RX9;
    localparam logic [31:0] S_AV = 32'h0000_0001 << `UBR_S_AVAIL;
    localparam logic [31:0] S_OV = 32'h0000_0001 << `UBR_S_OVR;
    localparam logic [31:0] S_FE = 32'h0000_0001 << `UBR_S_FRAME_ERR_FLAG;
    localparam logic [31:0] S_PE = 32'h0000_0001 << `UBR_S_PARITY_ERR_FLAG;
    localparam logic [31:0] S_ID = 32'h0000_0001 << `UBR_S_IDLE;
    logic i_clk = 1'b0;
    logic i_arst_n = 1'b0;
    ubr_wb_req_s wb_req = '0;
    logic [31:0] o_wb_dat;
    logic o_wb_ack;
    logic o_tx;
    logic o_tx_oe;
    logic o_rx_irq;
    logic rx_line;
    logic [31:0] rd;
    int error_cnt = 0;
    int tests_run = 0;
    int irq_cnt = 0;
    int n;
    ubr_uart ubr_uart_i (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_ce(1'b1),
        .i_wb(wb_req), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack),
        .i_rx(rx_line), .o_tx(o_tx), .o_tx_oe(o_tx_oe),
        .o_rx_irq(o_rx_irq));
    ubr_remote #(.BIT(BIT)) ubr_remote_i (.i_clk(i_clk), .i_line_in(o_tx),
        .o_line_out(rx_line));
    initial forever #2.5 i_clk = ~i_clk;
    always @(posedge i_clk)
    begin
        if (o_rx_irq === 1'b1)
            irq_cnt <= irq_cnt + 1;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic wb(input logic we, input logic [3:0] adr,
        input logic [31:0] wd, output logic [31:0] q);
        int k;
        @(posedge i_clk);
        wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hF, adr: adr,
            dat: wd};
        k = 0;
        do
        begin
            @(posedge i_clk);
            k++;
        end while (o_wb_ack !== 1'b1 && k < 100);
        q = o_wb_dat;
        wb_req <= '0;
        if (k >= 100)
            error_cnt++;
    endtask : wb
    task automatic chk(input logic [31:0] got, input logic [31:0] mask,
        input logic [31:0] exp);
        tests_run++;
        if ((got & mask) !== exp)
        begin
            error_cnt++;
            $display("Error at %0t: got %h want %h", $time, got & mask, exp);
        end
    endtask : chk
    task automatic pop(output logic [31:0] d);
        logic [31:0] s;
        wb(1'b0, `UBR_OFS_STAT, 32'h0, s);
        wb(1'b0, `UBR_OFS_DATA, 32'h0, d);
    endtask : pop
    task automatic complete_run;
        $display("tests %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : complete_run
    initial
    begin
        #(300_000);
        error_cnt++;
        $display("Error at %0t: watchdog expired", $time);
        complete_run();
    end
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (10) @(posedge i_clk);
        i_arst_n <= 1'b1;
        wb(1'b0, `UBR_OFS_CTRL, 32'h0, rd);
        chk(rd, 32'h0000_01FF, 32'h0);
        wb(1'b0, `UBR_OFS_DIV, 32'h0, rd);
        chk(rd, 32'h0000_FFFF, 32'h0);
        wb(1'b1, 4'h2, 32'hFFFF_FFFF, rd);
        wb(1'b0, 4'h2, 32'h0, rd);
        chk(rd, 32'hFFFF_FFFF, 32'h0);
        wb(1'b0, `UBR_OFS_CTRL, 32'h0, rd);
        chk(rd, 32'h0000_00FF, 32'h0);
        $display("test reset done");
        wb(1'b1, `UBR_OFS_DIV, DIV, rd);
        wb(1'b1, `UBR_OFS_CTRL, C_RX, rd);
        n = irq_cnt;
        fork
            ubr_remote_i.send(10'h0A5, 8, 1'b1);
            begin
                repeat (4 * BIT) @(posedge i_clk);
                wb(1'b0, `UBR_OFS_STAT, 32'h0, rd);
                chk(rd, S_ID, 32'h0);
            end
        join
        chk(32'(irq_cnt - n), 32'hFFFF_FFFF, 32'h1);
        wb(1'b1, `UBR_OFS_DIV, DIV, rd);
        wb(1'b0, `UBR_OFS_DATA, 32'h0, rd);
        wb(1'b0, `UBR_OFS_STAT, 32'h0, rd);
        chk(rd, S_AV | S_ID, S_AV | S_ID);
        pop(rd);
        chk(rd, 32'h0000_01FF, 32'h0A5);
        wb(1'b0, `UBR_OFS_STAT, 32'h0, rd);
        chk(rd, S_AV, 32'h0);
        $display("test single word done");
        n = irq_cnt;
        ubr_remote_i.send(10'h011, 8, 1'b1);
        ubr_remote_i.send(10'h022, 8, 1'b1);
        ubr_remote_i.send(10'h033, 8, 1'b1);
        chk(32'(irq_cnt - n), 32'hFFFF_FFFF, 32'h3);
        wb(1'b0, `UBR_OFS_STAT, 32'h0, rd);
        chk(rd, S_AV | S_OV, S_AV | S_OV);
        pop(rd);
        chk(rd, 32'h0000_01FF, 32'h011);
        pop(rd);
        chk(rd, 32'h0000_01FF, 32'h022);
        wb(1'b0, `UBR_OFS_STAT, 32'h0, rd);
        chk(rd, S_AV, 32'h0);
        $display("test overrun done");
        ubr_remote_i.send(10'h055, 8, 1'b0);
        wb(1'b0, `UBR_OFS_STAT, 32'h0, rd);
        chk(rd, S_AV | S_FE, S_AV | S_FE);
        pop(rd);
        chk(rd, 32'h0000_01FF, 32'h055);
        n = irq_cnt;
        ubr_remote_i.hold_low(20);
        wb(1'b0, `UBR_OFS_STAT, 32'h0, rd);
        chk(rd, S_AV | S_FE | S_ID, S_AV | S_FE | S_ID);
        chk(32'(irq_cnt - n), 32'hFFFF_FFFF, 32'h1);
        pop(rd);
        chk(rd, 32'h0000_01FF, 32'h0);
        ubr_remote_i.send(10'h03C, 8, 1'b1);
        wb(1'b0, `UBR_OFS_STAT, 32'h0, rd);
        chk(rd, S_AV | S_FE, S_AV);
        pop(rd);
        chk(rd, 32'h0000_01FF, 32'h03C);
        $display("test framing and break done");
        wb(1'b1, `UBR_OFS_CTRL, C_RX | C_NINE | C_PAR, rd);
        ubr_remote_i.send(10'h103, 9, 1'b1);
        wb(1'b0, `UBR_OFS_STAT, 32'h0, rd);
        chk(rd, S_AV | S_PE, S_AV | S_PE);
        pop(rd);
        chk(rd, 32'h0000_01FF, 32'h103);
        wb(1'b0, `UBR_OFS_CTRL, 32'h0, rd);
        chk(rd, C_R9, C_R9);
        ubr_remote_i.send(10'h101, 9, 1'b1);
        wb(1'b0, `UBR_OFS_STAT, 32'h0, rd);
        chk(rd, S_AV | S_PE, S_AV);
        pop(rd);
        chk(rd, 32'h0000_01FF, 32'h101);
        $display("test parity and nine bit done");
        n = irq_cnt;
        wb(1'b1, `UBR_OFS_CTRL, C_RX | C_TX | C_BRK, rd);
        @(posedge i_clk);
        chk({31'h0, o_tx_oe}, 32'h0000_0001, 32'h1);
        repeat (40 * BIT) @(posedge i_clk);
        wb(1'b1, `UBR_OFS_CTRL, C_RX | C_TX, rd);
        repeat (30 * BIT) @(posedge i_clk);
        chk(32'((ubr_remote_i.last_low - BIT) % (13 * BIT)), 32'hFFFF_FFFF,
            32'h0);
        chk(32'(ubr_remote_i.last_low >= 27 * BIT), 32'hFFFF_FFFF,
            32'h1);
        chk({31'h0, o_tx}, 32'h0000_0001, 32'h1);
        chk(32'(irq_cnt - n), 32'hFFFF_FFFF, 32'h0);
        $display("test break send done");
        complete_run();
    end
endmodule : tb
